// ### src/cmc_pkg.sv
package cmc_pkg;
	// control register field positions
	localparam int ENABLE_BIT          = 7;
	localparam int INITIALIZE_BIT      = 6;
	localparam int READY_BIT           = 5;
	localparam int SCALE_MSB           = 4;
	localparam int SCALE_LSB           = 2;
	localparam int SOURCE_MSB          = 1;
	localparam int SOURCE_LSB          = 0;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [7:0] MULTIPLIER_RESET_VALUE = 8'h00;
	// input source codes
	localparam logic [1:0] SRC_INT_HALF = 2'h0;
	localparam logic [1:0] SRC_EXT      = 2'h1;
	localparam logic [1:0] SRC_EXT_HALF = 2'h2;
	// output scale: codes up to this one pass every pulse
	localparam logic [2:0] SCALE_UNITY_MAX = 3'h2;
	localparam logic [2:0] SCALE_KEEP      = 3'h2;
	// pulses emitted per selected input period
	localparam logic [2:0] PULSES_PER_PERIOD = 3'h4;
	// period counter: saturation marks an input below the minimum input frequency
	localparam int PERIOD_W = 12;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 12'hfff;
	// spacing of the four pulses when the input is too slow
	localparam logic [PERIOD_W-1:0] FAST_GAP = 12'h002;
	// consecutive input edges seen after initialize before ready is reported
	localparam logic [3:0] LOCK_EDGES = 4'h8;
	// settle time software keeps between enable and initialize
	localparam int CORE_CLK_HZ      = 40000000;
	localparam int ENABLE_SETTLE_NS = 5000;
	localparam int ENABLE_SETTLE_CYCLES = (ENABLE_SETTLE_NS * (CORE_CLK_HZ / 1000000) + 999) / 1000;
	typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_LOCKING, ST_LOCKED} cmc_state_type;
endpackage

// ### src/cmc_burst_gen.sv
`timescale 1ns/10ps
// measures the selected input period and spreads four pulses over it
module cmc_burst_gen (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic in_edge,
	output logic      burst_pulse
);
	logic [cmc_pkg::PERIOD_W-1:0] period_reg, period_next;
	logic [cmc_pkg::PERIOD_W-1:0] gap_reg, gap_next;
	logic [cmc_pkg::PERIOD_W-1:0] space_reg, space_next;
	logic [2:0]                   left_reg, left_next;
	logic                         pulse_reg, pulse_next;

	// quarter period spacing; a saturated period means a slow input, so burst fast and idle
	always_comb begin
		period_next = (period_reg == cmc_pkg::PERIOD_MAX) ? period_reg
			: period_reg + 1'b1;
		gap_next    = gap_reg;
		space_next  = space_reg;
		left_next   = left_reg;
		pulse_next  = 1'b0;
		if (!run) begin
			period_next = '0;
			left_next   = '0;
			gap_next    = '0;
		end else if (in_edge) begin
			period_next = '0;
			pulse_next  = 1'b1;
			left_next   = cmc_pkg::PULSES_PER_PERIOD - 3'h1;
			if (period_reg == cmc_pkg::PERIOD_MAX)
				space_next = cmc_pkg::FAST_GAP;
			else if (period_reg[cmc_pkg::PERIOD_W-1:2] == '0)
				space_next = {{(cmc_pkg::PERIOD_W-1){1'b0}}, 1'b1};
			else
				space_next = {2'h0, period_reg[cmc_pkg::PERIOD_W-1:2]};
			gap_next = space_next;
		end else if (left_reg != '0) begin
			if (gap_reg <= {{(cmc_pkg::PERIOD_W-1){1'b0}}, 1'b1}) begin
				pulse_next = 1'b1;
				left_next  = left_reg - 3'h1;
				gap_next   = space_reg;
			end else begin
				gap_next = gap_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period_reg <= '0;
			gap_reg    <= '0;
			space_reg  <= '0;
			left_reg   <= '0;
			pulse_reg  <= 1'b0;
		end else begin
			period_reg <= period_next;
			gap_reg    <= gap_next;
			space_reg  <= space_next;
			left_reg   <= left_next;
			pulse_reg  <= pulse_next;
		end
	end

	assign burst_pulse = pulse_reg;
endmodule

// ### src/cmc_clock_multiplier_control.sv
`timescale 1ns/10ps
module cmc_clock_multiplier_control (
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic       EXT_OSC,
	input  wire logic       INT_OSC,
	output logic            MULT_CLK_PULSE,
	output logic            MULT_READY
);
	// register fields, sequencer state and the per-source edge logic
	logic                        enable_reg, enable_next;
	logic                        init_reg, init_next;
	logic [2:0]                  scale_reg, scale_next;
	logic [1:0]                  source_reg, source_next;
	cmc_pkg::cmc_state_type      state_reg, state_next;
	logic [3:0]                  lock_cnt_reg, lock_cnt_next;
	logic [1:0]                  osc_in;
	wire  [1:0]                  osc_rise, osc_half;
	logic                        ext_half, int_half;
	logic [2:0]                  scale_cnt_reg, scale_cnt_next;
	logic                        out_reg, out_next;
	// readback copy and the glue between the register groups
	logic [7:0]                  rdata_reg, rdata_next;
	logic                        ext_rise, int_rise, sel_edge, burst_pulse, ready;
	logic [2:0]                  scale_mod;

	// one edge detector and toggle halver per source, index 0 external and 1 internal;
	// halving keeps every other rising edge, so the x2 bases need no second clock
	assign osc_in = {INT_OSC, EXT_OSC};
	for (genvar i = 0; i < 2; i++) begin : g_src
		logic prev_reg, prev_next;
		logic half_reg, half_next;

		always_comb begin
			prev_next = osc_in[i];
			half_next = half_reg;
			if (osc_in[i] && !prev_reg)
				half_next = ~half_reg;
		end

		// prev starts low like an idle source, so a source already high when reset ends gives one edge
		always_ff @(posedge CORE_CLK or posedge RST) begin
			if (RST) begin
				prev_reg <= 1'b0;
				half_reg <= 1'b0;
			end else begin
				prev_reg <= prev_next;
				half_reg <= half_next;
			end
		end

		assign osc_rise[i] = osc_in[i] & ~prev_reg;
		assign osc_half[i] = half_reg;
	end
	assign ext_rise = osc_rise[0];
	assign int_rise = osc_rise[1];
	assign ext_half = osc_half[0];
	assign int_half = osc_half[1];

	// source mux; times four after halving gives the x2 and x4 bases
	// code 11 is unused and falls back to the halved external source,
	// so a stray write still yields a legal base
	always_comb begin
		case (source_reg)
			cmc_pkg::SRC_EXT:      sel_edge = ext_rise;
			cmc_pkg::SRC_EXT_HALF: sel_edge = ext_rise & ~ext_half;
			cmc_pkg::SRC_INT_HALF: sel_edge = int_rise & ~int_half;
			default:               sel_edge = ext_rise & ~ext_half;
		endcase
	end

	// the burst generator runs from enable, not ready, so its period
	// estimate is already settled when lock is reported
	cmc_burst_gen u_burst (
		.clk         (CORE_CLK),
		.rst         (RST),
		.run         (enable_reg),
		.in_edge     (sel_edge),
		.burst_pulse (burst_pulse)
	);

	// control register writes and the enable / initialize / lock sequence;
	// a write replaces every field at once, and bit 5 of the written byte
	// is dropped because ready is status only
	always_comb begin
		enable_next   = enable_reg;
		init_next     = init_reg;
		scale_next    = scale_reg;
		source_next   = source_reg;
		state_next    = state_reg;
		lock_cnt_next = lock_cnt_reg;
		case (state_reg)
			cmc_pkg::ST_OFF:     state_next = cmc_pkg::ST_OFF;
			cmc_pkg::ST_ARMED:   state_next = cmc_pkg::ST_ARMED;
			cmc_pkg::ST_LOCKING: begin
				// ready only after a run of real input edges, so a dead source never locks
				if (sel_edge)
					lock_cnt_next = lock_cnt_reg + 4'h1;
				if (lock_cnt_reg >= cmc_pkg::LOCK_EDGES)
					state_next = cmc_pkg::ST_LOCKED;
			end
			cmc_pkg::ST_LOCKED:  state_next = cmc_pkg::ST_LOCKED;
			default:             state_next = cmc_pkg::ST_OFF;
		endcase
		if (REG_WR) begin
			enable_next = REG_WDATA[cmc_pkg::ENABLE_BIT];
			init_next   = REG_WDATA[cmc_pkg::INITIALIZE_BIT];
			scale_next  = REG_WDATA[cmc_pkg::SCALE_MSB:cmc_pkg::SCALE_LSB];
			source_next = REG_WDATA[cmc_pkg::SOURCE_MSB:cmc_pkg::SOURCE_LSB];
			if (REG_WDATA == cmc_pkg::MULTIPLIER_RESET_VALUE) begin
				state_next    = cmc_pkg::ST_OFF;
				lock_cnt_next = '0;
			end else if (!REG_WDATA[cmc_pkg::ENABLE_BIT]) begin
				state_next    = cmc_pkg::ST_OFF;
				lock_cnt_next = '0;
			end else if (!enable_reg) begin
				// enabling write arms only; initialize in the same write is ignored
				state_next    = cmc_pkg::ST_ARMED;
				lock_cnt_next = '0;
			end else if (REG_WDATA[cmc_pkg::INITIALIZE_BIT] && !init_reg) begin
				state_next    = cmc_pkg::ST_LOCKING;
				lock_cnt_next = '0;
			end
		end
	end

	// ready is decoded from the state register, so it falls on the same edge
	// as a disabling write; the readback copy follows one edge later
	assign ready = (state_reg == cmc_pkg::ST_LOCKED);

	// keep two of every n pulses for the 2/n factors; low codes pass all
	// the phase counter restarts whenever lock is lost, so every new lock
	// starts with a kept pulse
	assign scale_mod = scale_reg + 3'h0;
	always_comb begin
		scale_cnt_next = scale_cnt_reg;
		out_next       = 1'b0;
		if (!ready) begin
			scale_cnt_next = '0;
		end else if (burst_pulse) begin
			if (scale_reg <= cmc_pkg::SCALE_UNITY_MAX) begin
				out_next = 1'b1;
			end else begin
				out_next = (scale_cnt_reg < cmc_pkg::SCALE_KEEP);
				scale_cnt_next = (scale_cnt_reg == scale_mod - 3'h1) ? 3'h0
					: scale_cnt_reg + 3'h1;
			end
		end
	end

	// readback: ready is status only, writes never reach it
	// fields come from the live registers, so the copy lags them by one edge
	always_comb begin
		rdata_next = {enable_reg, init_reg, ready, scale_reg, source_reg};
	end

	// control fields and sequencer state
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			enable_reg    <= cmc_pkg::CONTROL_RESET[cmc_pkg::ENABLE_BIT];
			init_reg      <= cmc_pkg::CONTROL_RESET[cmc_pkg::INITIALIZE_BIT];
			scale_reg     <= cmc_pkg::CONTROL_RESET[cmc_pkg::SCALE_MSB:cmc_pkg::SCALE_LSB];
			source_reg    <= cmc_pkg::CONTROL_RESET[cmc_pkg::SOURCE_MSB:cmc_pkg::SOURCE_LSB];
			state_reg     <= cmc_pkg::ST_OFF;
			lock_cnt_reg  <= '0;
		end else begin
			enable_reg    <= enable_next;
			init_reg      <= init_next;
			scale_reg     <= scale_next;
			source_reg    <= source_next;
			state_reg     <= state_next;
			lock_cnt_reg  <= lock_cnt_next;
		end
	end

	// output scaler phase and the registered output pulse
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			scale_cnt_reg <= '0;
			out_reg       <= 1'b0;
		end else begin
			scale_cnt_reg <= scale_cnt_next;
			out_reg       <= out_next;
		end
	end

	// readback copy; one edge of lag buys a glitch-free bus value
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rdata_reg     <= cmc_pkg::CONTROL_RESET;
		end else begin
			rdata_reg     <= rdata_next;
		end
	end

	// data outputs straight from flops, ready from the state flops
	assign REG_RDATA      = rdata_reg;
	assign MULT_CLK_PULSE = out_reg;
	assign MULT_READY     = ready;
endmodule

// ### testbench/cmc_clock_multiplier_control_monitor.sv
`timescale 1ns/10ps
module cmc_clock_multiplier_control_monitor (
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       EXT_OSC,
	input wire logic       INT_OSC,
	input wire logic       MULT_CLK_PULSE,
	input wire logic       MULT_READY
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// written fields come back two edges on; bit 5 is status, not storage
	AST_FIELDS: assert property (REG_WR |-> ##2
		{REG_RDATA[7:6], REG_RDATA[4:0]} == $past({REG_WDATA[7:6], REG_WDATA[4:0]}, 2))
		else $error("readback fields wrong");
	AST_ZERO_WRITE: assert property (REG_WR && REG_WDATA == 8'h00 |-> ##2 REG_RDATA == 8'h00)
		else $error("zero write not seen");
	AST_OFF_CLEARS: assert property (REG_WR && !REG_WDATA[7] |=> !MULT_READY [*3])
		else $error("ready kept after disable");
	AST_READY_BIT: assert property (REG_RDATA[5] == $past(MULT_READY))
		else $error("ready bit wrong");
	AST_READY_NEEDS_EN: assert property (MULT_READY |-> REG_RDATA[7])
		else $error("ready while disabled");
	AST_PULSE_LOCKED: assert property (MULT_CLK_PULSE |-> MULT_READY || $past(MULT_READY))
		else $error("pulse while unlocked");
	// locking counts eight input edges, so ready cannot follow initialize at once
	AST_LOCK_TIME: assert property (REG_WR && REG_WDATA[7:6] == 2'h3 &&
		REG_RDATA[7:6] == 2'h2 |=> !MULT_READY [*8])
		else $error("ready too early");
	AST_READY_AFTER_INIT: assert property ($rose(MULT_READY) |-> REG_RDATA[7:6] == 2'h3)
		else $error("ready without initialize");
	COV_LOCK: cover property ($rose(MULT_READY));
	COV_PULSE: cover property (MULT_CLK_PULSE ##2 MULT_CLK_PULSE);
	COV_OFF: cover property (MULT_READY ##1 !MULT_READY);
endmodule
bind cmc_clock_multiplier_control cmc_clock_multiplier_control_monitor u_mon (
	.CORE_CLK(CORE_CLK), .RST(RST), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .EXT_OSC(EXT_OSC), .INT_OSC(INT_OSC),
	.MULT_CLK_PULSE(MULT_CLK_PULSE), .MULT_READY(MULT_READY));

// ### testbench/cmc_osc_model.sv
`timescale 1ns/10ps
// oscillator sources; the bench retunes them through the half-period inputs
module cmc_osc_model (
	input  wire logic        clk,
	input  wire logic [15:0] ext_half,
	input  wire logic [15:0] int_half,
	output logic             ext_osc = 1'b0,
	output logic             int_osc = 1'b0
);
	logic [15:0] ext_cnt_reg = 16'h0000;
	logic [15:0] int_cnt_reg = 16'h0000;
	// free running from time zero, so the external source is settled before initialize
	always @(negedge clk) begin
		ext_cnt_reg <= ext_cnt_reg + 16'h0001;
		int_cnt_reg <= int_cnt_reg + 16'h0001;
		if (ext_cnt_reg >= ext_half - 16'h0001) begin
			ext_cnt_reg <= 16'h0000;
			ext_osc     <= ~ext_osc;
		end
		if (int_cnt_reg >= int_half - 16'h0001) begin
			int_cnt_reg <= 16'h0000;
			int_osc     <= ~int_osc;
		end
	end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        ext_osc, int_osc, pulse, ready;
	logic [15:0] ext_half = 16'h0008;
	logic [15:0] int_half = 16'h000c;
	logic [7:0]  exp_q[$];
	int          cnt_q[$];
	logic [2:0]  wp = 3'h0;
	logic        meas = 1'b0;
	logic        meas_d = 1'b0;
	logic        meas_s = 1'b0;
	int          pcount = 0;
	int          bad_count = 0;
	int          n_tests = 0;
	logic [31:0] lfsr = 32'h2148;
	cmc_clock_multiplier_control u_dut (.CORE_CLK(clk), .RST(rst), .REG_WR(wr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .EXT_OSC(ext_osc), .INT_OSC(int_osc),
		.MULT_CLK_PULSE(pulse), .MULT_READY(ready));
	cmc_osc_model u_osc (.clk(clk), .ext_half(ext_half), .int_half(int_half),
		.ext_osc(ext_osc), .int_osc(int_osc));
	always #12.5 clk = ~clk;
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic bad(input string msg);
		bad_count++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) bad($sformatf("readback %h want %h", got, exp));
	endtask
	task automatic check_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) bad("ready level wrong");
	endtask
	task automatic check_count(input int got, input int exp);
		n_tests++;
		if (got != exp) bad($sformatf("pulses %0d want %0d", got, exp));
	endtask
	// one write; ready is never up two edges after any write here, so bit 5 reads 0
	task automatic write_reg(input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		wdata = d;
		exp_q.push_back(d & 8'hdf);
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic measure(input int exp, input int w);
		cnt_q.push_back(exp);
		meas = 1'b1;
		repeat (w) @(negedge clk);
		meas = 1'b0;
	endtask
	// wr and meas are taken on the rising edge, so the falling-edge watcher never races the driver
	always @(posedge clk) begin
		wp     <= {wp[1:0], wr};
		meas_s <= meas;
	end
	// watcher on settled outputs: readback two edges after the write, pulse totals per span
	always @(negedge clk) begin
		if (wp[1] && exp_q.size() > 0)
			check_byte(rdata, exp_q.pop_front());
		if (meas_s)
			pcount = pcount + ((pulse === 1'b0) ? 0 : 1);
		if (!meas_s && meas_d) begin
			check_count(pcount, cnt_q.pop_front());
			pcount = 0;
		end
		meas_d = meas_s;
	end
	// full bring-up, then 105 input periods: 420 base pulses divide by every scale
	task automatic run_mode(input logic [1:0] src, input logic [2:0] scale, input int per);
		int k;
		logic [7:0] cfg;
		cfg = {3'h0, scale, src};
		write_reg(8'h00);
		write_reg({6'h00, src});
		write_reg(cfg);
		write_reg(cfg | 8'h80);
		repeat (cmc_pkg::ENABLE_SETTLE_CYCLES) @(negedge clk);
		write_reg(cfg | 8'hc0);
		k = 0;
		while (ready !== 1'b1 && k < 40 * per) begin
			@(negedge clk);
			k++;
		end
		check_bit(ready, 1'b1);
		repeat (4 * per) @(negedge clk);
		measure(scale < 3'h3 ? 420 : 840 / scale, 105 * per);
		$display("test source %0d scale %0d done", src, scale);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		run_mode(2'h0, 3'h0, 48);
		run_mode(2'h2, 3'h1, 32);
		run_mode(2'h3, 3'h2, 32);
		for (int s = 7; s >= 0; s--)
			run_mode(2'h1, s[2:0], 16);
		ext_half = 16'h0834;
		repeat (3) @(posedge ext_osc);
		measure(4, 12);
		@(negedge clk);
		measure(0, 4176);
		$display("test slow input done");
		ext_half = 16'h0008;
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			write_reg(lfsr[7:0] & 8'h7f);
			check_bit(ready, 1'b0);
		end
		$display("test random disable done");
		write_reg(8'h00);
		write_reg(8'hc1);
		repeat (400) @(negedge clk);
		check_bit(ready, 1'b0);
		$display("test early initialize done");
		repeat (4) @(negedge clk);
		finish_test();
	end
	initial begin
		#2200000;
		bad("watchdog expired");
		finish_test();
	end
	task automatic finish_test();
		$display("tests %0d bad %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
endmodule
